// ===== hdl/seq_pkg.sv
// constants, command codes and types for the record/playback sequencer
// assumes a 32-bit classic Wishbone slave view, word aligned byte addresses
//
// Functional notes
// - level code picks trigger threshold, 00 disables
// - direct mode ignores partition bits, keeps rate
// - indirect bit 0 selects direct mode, channel
// - direct address write fills selected index entry
// - record arm sets recording mode for start
// - direct start loads index into counter, stop
// - counter equal stop ends, active flag clears
// - stop in recording stores counter as stop
// - fixed start generates addresses, writes index too
// - flex start uses previous stop plus one
// - indirect bit 1, partition bits pick fixed/flex
// - flex end of memory sets full flag
// - playback ignores level code, keeps bit length
// - play arms playback, start loads stored addresses
// - playback accepts any channel number
// - pause suspends, start resumes, both flags one
// - start during pause resumes without voice
// - pause ignored in standby, pause, voice wait
// - stop during pause ends, returns to standby
// - voice wait flag set, cleared on detection
// - silence dropped only before first detection
// - stop in voice wait gives recording standby
// - stop in playback leaves index untouched
package seq_pkg;
	// register byte addresses
	localparam logic [7:0] ADR_VOICE  = 8'h00;
	localparam logic [7:0] ADR_RATE   = 8'h04;
	localparam logic [7:0] ADR_CHANNEL_SELECT_CMD   = 8'h08;
	localparam logic [7:0] ADR_ADDRW  = 8'h0c;
	localparam logic [7:0] ADR_CMD    = 8'h10;
	localparam logic [7:0] ADR_STATUS = 8'h14;
	localparam logic [7:0] ADR_COUNT  = 8'h18;
	localparam logic [7:0] ADR_INDEX  = 8'h1c;
	localparam logic [3:0] SEL_ALL    = 4'hf;
	// field positions
	localparam int VS_LVL = 0;
	localparam int VS_BIT = 2;
	localparam int RS_RATE = 0;
	localparam int RS_PSEL = 2;
	localparam int CS_CH = 0;
	localparam int CS_IND = 3;
	localparam int AW_START = 20;
	// command codes in the low nibble of the command register
	localparam logic [3:0] CMD_REC   = 4'h1;
	localparam logic [3:0] CMD_PLAY  = 4'h2;
	localparam logic [3:0] CMD_START = 4'h3;
	localparam logic [3:0] CMD_STOP  = 4'h4;
	localparam logic [3:0] CMD_PAUSE = 4'h5;
	// detect level codes
	localparam logic [1:0] LVL_OFF   = 2'h0;
	localparam logic [1:0] LVL_DIV64 = 2'h1;
	localparam logic [1:0] LVL_DIV32 = 2'h2;
	localparam logic [1:0] LVL_DIV16 = 2'h3;
	// memory map of the voice area
	localparam logic [11:0] MEM_FIRST_X = 12'h008;
	localparam logic [11:0] MEM_LAST_X  = 12'hfff;
	localparam logic [7:0]  TAIL_Y3     = 8'ha9;
	localparam logic [7:0]  TAIL_Y4     = 8'h7f;
	localparam logic [11:0] SEG8_X      = 12'h1ff;
	localparam logic [11:0] SEG4_X      = 12'h3fe;
	localparam logic [11:0] SEG2_X      = 12'h7fc;
	// reset values
	localparam logic [7:0]  RST_SETUP   = 8'h00;
	localparam logic [19:0] RST_ADDR    = 20'h00000;
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_VWAIT = 2'b01,
		ST_RUN   = 2'b10,
		ST_PAUSE = 2'b11
	} state_t;
	typedef enum logic [2:0] {
		MODE_DIRECT = 3'b000,
		MODE_FIXED8 = 3'b001,
		MODE_FIXED4 = 3'b010,
		MODE_FIXED2 = 3'b011,
		MODE_FLEX   = 3'b100
	} ctrl_t;
endpackage : seq_pkg

// ===== hdl/record_playback_sequencer.sv
// command sequencer for record and playback with channel index area
// assumes a classic Wishbone master, a codec pulsing i_word_done per stored
// word on this clock, and an asynchronous voice detector pin
`timescale 1ns/1ps
module record_playback_sequencer
	import seq_pkg::*;
(
	input  wire logic        I_CLK,
	input  wire logic        I_RESET,
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [7:0]  I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic      [31:0] O_WB_DAT,
	output logic             O_WB_ACK,
	input  wire logic        I_VOICE_DETECT,
	input  wire logic        I_WORD_DONE,
	output logic      [19:0] O_ADDR,
	output logic             O_RECORDING,
	output logic             O_PLAYING,
	output logic      [1:0]  O_DETECT_LEVEL,
	output logic             O_ADPCM_4BIT,
	output logic      [1:0]  O_RATE_CODE
);
	state_t      state;
	state_t      next_state;
	logic [7:0]  voice_setup;
	logic [7:0]  rate_setup;
	logic [7:0]  channel_select_cmd_setup;
	logic        rec_mode;
	logic        armed;
	logic        mem_full;
	logic [19:0] addr;
	logic [19:0] stop_addr;
	logic [11:0] idx_start [8];
	logic [19:0] idx_stop  [8];
	logic [2:0]  vsync;
	logic        voice;

	// fixed segment length in X units for the partition choice
	function automatic logic [11:0] seg_len(input ctrl_t m);
		case (m)
			MODE_FIXED4: seg_len = SEG4_X;
			MODE_FIXED2: seg_len = SEG2_X;
			default:     seg_len = SEG8_X;
		endcase
	endfunction : seg_len

	// bus decode; writes commit on the edge at which the master sees ack
	wire logic       req      = I_WB_CYC & I_WB_STB;
	wire logic       fire     = req & O_WB_ACK & I_WB_WE & (I_WB_SEL == SEL_ALL);
	wire logic       wr_voice = fire & (I_WB_ADR == ADR_VOICE);
	wire logic       wr_rate  = fire & (I_WB_ADR == ADR_RATE);
	wire logic       wr_channel_select_cmd  = fire & (I_WB_ADR == ADR_CHANNEL_SELECT_CMD);
	wire logic       wr_addrw = fire & (I_WB_ADR == ADR_ADDRW);
	wire logic       wr_cmd   = fire & (I_WB_ADR == ADR_CMD);
	wire logic [3:0] cmd      = I_WB_DAT[3:0];
	wire logic       do_rec   = wr_cmd & (cmd == CMD_REC);
	wire logic       do_play  = wr_cmd & (cmd == CMD_PLAY);
	wire logic       do_start = wr_cmd & (cmd == CMD_START);
	wire logic       do_stop  = wr_cmd & (cmd == CMD_STOP);
	wire logic       do_pause = wr_cmd & (cmd == CMD_PAUSE);

	// setup fields
	wire logic [1:0] lvl     = voice_setup[VS_LVL +: 2];
	wire logic       bit4    = voice_setup[VS_BIT];
	wire logic [1:0] psel    = rate_setup[RS_PSEL +: 2];
	wire logic [2:0] ch      = channel_select_cmd_setup[CS_CH +: 3];
	wire logic       indir   = channel_select_cmd_setup[CS_IND];
	wire logic       vt_on   = (lvl != LVL_OFF);

	// control mode; partition bits only count when indirect is set
	wire ctrl_t      mode    = !indir ? MODE_DIRECT :
		(psel == 2'b11) ? MODE_FLEX : ctrl_t'(3'(psel) + 3'h1);
	wire logic       flex    = (mode == MODE_FLEX);
	wire logic       direct  = (mode == MODE_DIRECT);
	wire logic [7:0] tail_y  = bit4 ? TAIL_Y4 : TAIL_Y3;

	// fixed addresses are generated from the channel's slot
	wire logic [11:0] seg     = seg_len(mode);
	wire logic [11:0] fix_x   = 12'(MEM_FIRST_X + 12'(ch) * seg);
	wire logic [19:0] fix_st  = {fix_x, 8'h00};
	wire logic [19:0] fix_sp  = {12'(fix_x + seg - 12'h001), tail_y};
	// flex continues after the previous channel up to the last address
	wire logic [2:0]  prev_ch = 3'(ch - 3'h1);
	wire logic [19:0] flx_st  = (ch == 3'h0) ? {MEM_FIRST_X, 8'h00} :
		20'(idx_stop[prev_ch] + 20'h00001);
	wire logic [19:0] flx_sp  = {MEM_LAST_X, tail_y};
	// playback and direct recording use what the index holds
	wire logic [19:0] idx_st  = {idx_start[ch], 8'h00};
	wire logic        gen     = rec_mode & !direct;
	wire logic [19:0] ld_st   = !gen ? idx_st : flex ? flx_st : fix_st;
	wire logic [19:0] ld_sp   = !gen ? idx_stop[ch] : flex ? flx_sp : fix_sp;

	// start from standby; flex recording refused on channels other than 0 once memory is full
	wire logic blocked   = rec_mode & flex & mem_full & (ch != 3'h0);
	wire logic start_go  = do_start & (state == ST_IDLE) & armed & !blocked;
	wire logic match     = (state == ST_RUN) & (addr == stop_addr);
	wire logic stop_rec  = do_stop & rec_mode &
		((state == ST_RUN) | (state == ST_PAUSE));
	wire logic op_active  = (state == ST_RUN) | (state == ST_PAUSE);
	wire logic voice_wait = (state == ST_VWAIT) | (state == ST_PAUSE);

	// voice pin synchroniser; a change counts once the last two agree
	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			vsync <= 3'h0;
			voice <= 1'b0;
		end else begin
			vsync <= {vsync[1:0], I_VOICE_DETECT};
			if (vsync[1] == vsync[2])
				voice <= vsync[2];
		end
	end

	// sequencing of standby, voice wait, running and pause
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (start_go)
					next_state = (rec_mode && vt_on) ? ST_VWAIT : ST_RUN;
			end
			ST_VWAIT: begin
				if (do_stop)
					next_state = ST_IDLE;
				else if (voice)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (do_stop || match)
					next_state = ST_IDLE;
				else if (do_pause)
					next_state = ST_PAUSE;
			end
			ST_PAUSE: begin
				if (do_stop)
					next_state = ST_IDLE;
				else if (do_start)
					next_state = ST_RUN;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// setup registers and arming; arm commands only taken in standby
	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			voice_setup <= RST_SETUP;
			rate_setup  <= RST_SETUP;
			channel_select_cmd_setup  <= RST_SETUP;
			rec_mode    <= 1'b0;
			armed       <= 1'b0;
		end else begin
			if (wr_voice)
				voice_setup <= I_WB_DAT[7:0];
			if (wr_rate)
				rate_setup <= I_WB_DAT[7:0];
			if (wr_channel_select_cmd)
				channel_select_cmd_setup <= I_WB_DAT[7:0];
			if ((do_rec || do_play) && state == ST_IDLE) begin
				rec_mode <= do_rec;
				armed    <= 1'b1;
			end
		end
	end

	// address counter and stop register; silence is not counted in voice wait
	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			addr      <= RST_ADDR;
			stop_addr <= RST_ADDR;
		end else if (start_go) begin
			addr      <= ld_st;
			stop_addr <= ld_sp;
		end else if (state == ST_RUN && I_WORD_DONE && !match) begin
			addr <= 20'(addr + 20'h00001);
		end
	end

	// channel index area; playback stop falls through with no write
	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			for (int i = 0; i < 8; i++) begin
				idx_start[i] <= 12'h000;
				idx_stop[i]  <= RST_ADDR;
			end
		end else if (wr_addrw && state == ST_IDLE) begin
			idx_start[ch] <= I_WB_DAT[AW_START +: 12];
			idx_stop[ch]  <= I_WB_DAT[19:0];
		end else if (start_go && gen) begin
			idx_start[ch] <= ld_st[19:8];
			idx_stop[ch]  <= ld_sp;
		end else if (stop_rec) begin
			idx_stop[ch] <= addr;
		end
	end

	// memory full: a flex recording that ran to the end; set beats clear
	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET)
			mem_full <= 1'b0;
		else if (match && rec_mode && flex && stop_addr[19:8] == MEM_LAST_X)
			mem_full <= 1'b1;
		else if (start_go && rec_mode && flex && ch == 3'h0)
			mem_full <= 1'b0;
	end

	// read mux; unmapped addresses read zero
	wire logic [31:0] rd_data =
		(I_WB_ADR == ADR_VOICE)  ? {24'h0, voice_setup} :
		(I_WB_ADR == ADR_RATE)   ? {24'h0, rate_setup} :
		(I_WB_ADR == ADR_CHANNEL_SELECT_CMD)   ? {24'h0, channel_select_cmd_setup} :
		(I_WB_ADR == ADR_STATUS) ? {27'h0, rec_mode, armed, mem_full, voice_wait,
			op_active} :
		(I_WB_ADR == ADR_COUNT)  ? {12'h0, addr} :
		(I_WB_ADR == ADR_INDEX)  ? {idx_start[ch], idx_stop[ch]} : 32'h0;

	// ack one cycle after the request, dropped the cycle after
	always_ff @(posedge I_CLK or posedge I_RESET) begin
		if (I_RESET) begin
			O_WB_ACK <= 1'b0;
			O_WB_DAT <= 32'h0;
		end else begin
			O_WB_ACK <= req & !O_WB_ACK;
			if (req && !O_WB_ACK)
				O_WB_DAT <= rd_data;
		end
	end

	// link outputs; threshold forced off while playing
	assign O_ADDR         = addr;
	assign O_RECORDING    = (state == ST_RUN) & rec_mode;
	assign O_PLAYING      = (state == ST_RUN) & !rec_mode;
	assign O_DETECT_LEVEL = rec_mode ? lvl : LVL_OFF;
	assign O_ADPCM_4BIT   = bit4;
	assign O_RATE_CODE    = rate_setup[RS_RATE +: 2];

	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RESET);

	sequence s_stop_in_run;
		state == ST_RUN && do_stop && !match;
	endsequence

	property p_vwait_flags;
		state == ST_VWAIT |-> voice_wait && !op_active;
	endproperty
	a_vwait_flags: assert property (p_vwait_flags) else $error("voice wait flags wrong");

	property p_pause_flags;
		state == ST_PAUSE |-> voice_wait && op_active;
	endproperty
	a_pause_flags: assert property (p_pause_flags) else $error("pause flags wrong");

	property p_match_end;
		match && !do_pause |=> state == ST_IDLE && !op_active;
	endproperty
	a_match_end: assert property (p_match_end) else $error("no end on match");

	property p_stop_writeback;
		s_stop_in_run ##0 rec_mode |=> idx_stop[$past(ch)] == $past(addr);
	endproperty
	a_stop_writeback: assert property (p_stop_writeback) else $error("stop not stored");

	property p_pause_ignored;
		do_pause && state != ST_RUN |=> state == $past(state) || state == ST_RUN;
	endproperty
	a_pause_ignored: assert property (p_pause_ignored) else $error("pause not ignored");

	property p_resume;
		state == ST_PAUSE && do_start && !do_stop |=> state == ST_RUN [*1];
	endproperty
	a_resume: assert property (p_resume) else $error("pause not resumed");

	property p_vwait_stop;
		state == ST_VWAIT && do_stop |=> state == ST_IDLE && rec_mode && armed;
	endproperty
	a_vwait_stop: assert property (p_vwait_stop) else $error("voice wait stop wrong");

	property p_play_stop;
		s_stop_in_run ##0 !rec_mode |=> idx_stop[$past(ch)] == $past(idx_stop[ch]);
	endproperty
	a_play_stop: assert property (p_play_stop) else $error("playback stop wrote index");

	property p_play_level;
		!rec_mode |-> O_DETECT_LEVEL == LVL_OFF;
	endproperty
	a_play_level: assert property (p_play_level) else $error("level not ignored");

	property p_direct_load;
		start_go && (!rec_mode || direct) |=> addr == $past(idx_st) && state != ST_IDLE;
	endproperty
	a_direct_load: assert property (p_direct_load) else $error("index not loaded");

	// a start while flex memory is full; only channel 0 may begin again
	sequence s_flex_full_start;
		do_start && state == ST_IDLE && armed && rec_mode && flex && mem_full;
	endsequence

	property p_arm_rec;
		do_rec && state == ST_IDLE |=> rec_mode && armed;
	endproperty
	a_arm_rec: assert property (p_arm_rec) else $error("record arm not taken");

	property p_direct_write;
		wr_addrw && state == ST_IDLE |=> idx_stop[$past(ch)] == $past(I_WB_DAT[19:0]) &&
			idx_start[$past(ch)] == $past(I_WB_DAT[AW_START +: 12]);
	endproperty
	a_direct_write: assert property (p_direct_write) else $error("index write lost");

	property p_fixed_load;
		start_go && gen && !flex |=> addr == $past(fix_st) && stop_addr == $past(fix_sp) &&
			idx_stop[$past(ch)] == $past(fix_sp);
	endproperty
	a_fixed_load: assert property (p_fixed_load) else $error("fixed load wrong");

	property p_flex_load;
		start_go && gen && flex |=> addr == $past(flx_st) && stop_addr == $past(flx_sp) &&
			idx_start[$past(ch)] == $past(flx_st[19:8]);
	endproperty
	a_flex_load: assert property (p_flex_load) else $error("flex load wrong");

	property p_full_set;
		match && rec_mode && flex && addr[19:8] == MEM_LAST_X |=> mem_full;
	endproperty
	a_full_set: assert property (p_full_set) else $error("full flag not set");

	property p_full_block;
		s_flex_full_start ##0 ch != 3'h0 |=> state == ST_IDLE && addr == $past(addr);
	endproperty
	a_full_block: assert property (p_full_block) else $error("start after full");

	property p_vwait_run;
		state == ST_VWAIT && voice && !do_stop |=>
			state == ST_RUN && op_active && !voice_wait;
	endproperty
	a_vwait_run: assert property (p_vwait_run) else $error("no run on voice");

	property p_vwait_hold;
		state == ST_VWAIT |=> addr == $past(addr);
	endproperty
	a_vwait_hold: assert property (p_vwait_hold) else $error("silence counted");
endmodule : record_playback_sequencer

// ===== verif/word_codec_model.sv
// codec stand-in that pulses once for each word stored or played
// assumes the sequencer run outputs come from the same clock
`timescale 1ns/1ps
module word_codec_model (
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_active,
	input  wire logic i_en,
	input  wire logic i_slow,
	output logic      o_word_done
);
	logic [1:0] gap;

	// a real codec never pulses outside a run; slow mode stretches the gap
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_word_done <= 1'b0;
			gap         <= 2'h0;
		end else if (o_word_done) begin
			o_word_done <= 1'b0;
			gap         <= i_slow ? 2'h2 : 2'h0;
		end else if (gap != 2'h0) begin
			gap <= gap - 2'h1;
		end else begin
			o_word_done <= i_active & i_en;
		end
	end
endmodule : word_codec_model

// ===== verif/record_playback_sequencer_tb.sv
// self-checking bench for the record/playback sequencer
// assumes the word codec model and the sequencer package are compiled first
`timescale 1ns/1ps
module record_playback_sequencer_tb;
	import seq_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic        voice = 1'b0;
	logic        en = 1'b0;
	logic        slow = 1'b0;
	logic [31:0] rdat;
	logic        ack;
	logic        word_done;
	logic [19:0] addr;
	logic        record_arm_cmd;
	logic        play;
	logic [1:0]  lvl;
	logic        adpcm4;
	logic [1:0]  rate;
	logic [31:0] expq[$];
	int          error_cnt = 0;
	int          checks = 0;
	int          cycles = 0;
	int          seed = 33;
	int          n;
	int          r;

	always #4 clk = ~clk;

	record_playback_sequencer i_dut (.I_CLK(clk), .I_RESET(rst), .I_WB_CYC(cyc),
		.I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat),
		.O_WB_DAT(rdat), .O_WB_ACK(ack), .I_VOICE_DETECT(voice), .I_WORD_DONE(word_done),
		.O_ADDR(addr), .O_RECORDING(record_arm_cmd), .O_PLAYING(play), .O_DETECT_LEVEL(lvl),
		.O_ADPCM_4BIT(adpcm4), .O_RATE_CODE(rate));

	word_codec_model i_codec (.i_clk(clk), .i_reset(rst), .i_active(record_arm_cmd | play),
		.i_en(en), .i_slow(slow), .o_word_done(word_done));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task stop_test;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test

	// one classic cycle: hold everything until ack is seen, then release
	task wb(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [3:0] s);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= s;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb

	task wr(input logic [7:0] a, input logic [31:0] d);
		wb(a, d, 1'b1, SEL_ALL);
	endtask : wr

	// the note goes in before the request so the watcher always finds it
	task rd(input logic [7:0] a, input logic [31:0] exp);
		expq.push_back(exp);
		wb(a, 32'h0, 1'b0, SEL_ALL);
	endtask : rd

	task cmd(input logic [3:0] c);
		wr(ADR_CMD, {28'h0, c});
	endtask : cmd

	// let the codec deliver k words, then hold it off
	task words(input int k);
		int got;
		got = 0;
		en <= 1'b1;
		while (got < k) begin
			@(posedge clk);
			if (word_done === 1'b1)
				got++;
		end
		en <= 1'b0;
	endtask : words

	// read answers are matched in order against the driver's notes
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			if (expq.size() > 0)
				chk(rdat, expq.pop_front());
			else
				chk(rdat, ~rdat);
		end
	end

	// a hung handshake ends the run instead of stalling it
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rd(ADR_STATUS, 32'h0);
		rd(ADR_INDEX, 32'h0);
		rd(8'h20, 32'h0);
		wr(8'h24, $random(seed));
		r = $random(seed) & 3;
		wr(ADR_VOICE, 32'h0);
		wr(ADR_RATE, {30'h3, r[1:0]});
		wr(ADR_CHANNEL_SELECT_CMD, 32'h2);
		wr(ADR_ADDRW, 32'h01001006);
		rd(ADR_INDEX, 32'h01001006);
		wb(ADR_VOICE, 32'h3, 1'b1, 4'h1);
		rd(ADR_VOICE, 32'h0);
		chk(rate, r[1:0]);
		cmd(CMD_PAUSE);
		rd(ADR_STATUS, 32'h0);
		cmd(CMD_REC);
		rd(ADR_STATUS, 32'h18);
		cmd(CMD_START);
		@(posedge clk);
		chk(addr, 20'h01000);
		chk({play, record_arm_cmd}, 2'h1);
		words(6);
		repeat (2) @(posedge clk);
		chk(addr, 20'h01006);
		chk({play, record_arm_cmd}, 2'h0);
		rd(ADR_STATUS, 32'h18);
		$display("direct record test done");
		n = 1 + ($random(seed) & 3);
		cmd(CMD_START);
		words(n);
		cmd(CMD_PAUSE);
		cmd(CMD_PAUSE);
		rd(ADR_STATUS, 32'h1b);
		chk(addr, 20'h01000 + n);
		cmd(CMD_START);
		rd(ADR_STATUS, 32'h19);
		words(1);
		cmd(CMD_STOP);
		rd(ADR_STATUS, 32'h18);
		rd(ADR_INDEX, 32'h01001001 + n);
		$display("stop and pause test done");
		wr(ADR_VOICE, 32'h5);
		cmd(CMD_PLAY);
		@(posedge clk);
		chk(lvl, 2'h0);
		chk(adpcm4, 1'b1);
		slow <= 1'b1;
		cmd(CMD_START);
		@(posedge clk);
		chk(addr, 20'h01000);
		chk({play, record_arm_cmd}, 2'h2);
		words(1);
		cmd(CMD_PAUSE);
		cmd(CMD_STOP);
		rd(ADR_STATUS, 32'h08);
		rd(ADR_INDEX, 32'h01001001 + n);
		$display("playback test done");
		cmd(CMD_REC);
		for (int k = 0; k < 4; k++) begin
			wr(ADR_VOICE, 32'h4 | k);
			@(posedge clk);
			chk(lvl, k[1:0]);
		end
		wr(ADR_VOICE, 32'h5);
		cmd(CMD_START);
		rd(ADR_STATUS, 32'h1a);
		chk(record_arm_cmd, 1'b0);
		cmd(CMD_STOP);
		rd(ADR_STATUS, 32'h18);
		cmd(CMD_START);
		voice <= 1'b1;
		repeat (8) @(posedge clk);
		rd(ADR_STATUS, 32'h19);
		cmd(CMD_PAUSE);
		voice <= 1'b0;
		repeat (8) @(posedge clk);
		cmd(CMD_START);
		rd(ADR_STATUS, 32'h19);
		cmd(CMD_STOP);
		rd(ADR_STATUS, 32'h18);
		$display("voice trigger test done");
		wr(ADR_VOICE, 32'h0);
		wr(ADR_RATE, {30'h1, r[1:0]});
		wr(ADR_CHANNEL_SELECT_CMD, 32'h9);
		cmd(CMD_START);
		@(posedge clk);
		chk(addr, 20'h40600);
		rd(ADR_INDEX, 32'h406803a9);
		cmd(CMD_STOP);
		wr(ADR_RATE, {30'h3, r[1:0]});
		wr(ADR_CHANNEL_SELECT_CMD, 32'h8);
		cmd(CMD_START);
		@(posedge clk);
		chk(addr, 20'h00800);
		rd(ADR_INDEX, 32'h008fffa9);
		rd(ADR_STATUS, 32'h19);
		words(2);
		cmd(CMD_STOP);
		wr(ADR_CHANNEL_SELECT_CMD, 32'h9);
		cmd(CMD_START);
		@(posedge clk);
		chk(addr, 20'h00803);
		cmd(CMD_STOP);
		rd(ADR_STATUS, 32'h18);
		// park channel 3 near the end so a flex channel 4 fills memory in 8 words
		wr(ADR_CHANNEL_SELECT_CMD, 32'h3);
		wr(ADR_ADDRW, 32'h000fffa0);
		wr(ADR_CHANNEL_SELECT_CMD, 32'hc);
		cmd(CMD_START);
		words(8);
		repeat (2) @(posedge clk);
		rd(ADR_STATUS, 32'h1c);
		wr(ADR_CHANNEL_SELECT_CMD, 32'hd);
		cmd(CMD_START);
		@(posedge clk);
		chk(addr, 20'hfffa9);
		chk({play, record_arm_cmd}, 2'h0);
		rd(ADR_STATUS, 32'h1c);
		$display("fixed and flex test done");
		stop_test();
	end
endmodule : record_playback_sequencer_tb
